// ===== pkg/port_regs_pkg.sv
// Register map, field layouts, reset values and bus widths of the port control block.
package port_regs_pkg;

  localparam int ADR_W = 34;
  localparam int DAT_W = 32;
  localparam int SEL_W = 4;

  typedef logic [ADR_W-1:0] adr_t;
  typedef logic [DAT_W-1:0] dat_t;
  typedef logic [SEL_W-1:0] sel_t;

  // Word indices; the byte address on the bus is four times the index.
  localparam logic [31:0] DRIVE_TYPE_IDX = 32'h0FFFFC72;
  localparam logic [31:0] DRIVE_HIGH_IDX = 32'h0FFFFC73;
  localparam logic [31:0] LATCH_IDX      = 32'hFFFFF004;
  localparam logic [31:0] DMODE_IDX      = 32'hFFFFF024;
  localparam logic [31:0] CMODE_IDX      = 32'hFFFFF02C;
  localparam logic [31:0] PIN_LEVEL_IDX  = 32'hFFFFF0F0;

  localparam int IDX_LSB = 2;

  localparam logic [15:0] DRIVE_RST      = 16'h0000;
  localparam logic [15:0] DRIVE_IMPL_MAX = 16'hFFDF;
  localparam logic [15:0] LATCH_RST      = 16'h0000;
  localparam logic [15:0] DMODE_RST      = 16'hFFFF;
  localparam logic [7:0]  CMODE_RST      = 8'hFF;

  localparam int LATCH_BIT = 5;
  localparam int DMODE_BIT = 5;
  localparam int CMODE_BIT = 0;

  localparam int LVL_PORTC_BIT = 0;
  localparam int LVL_PORTD_BIT = 1;
  localparam int LVL_FLASH_BIT = 2;

  localparam int PORT9_W = 16;
  localparam int SYNC_W  = 3;

endpackage

// ===== pkg/pin_ctrl_if.sv
// Carries per-bit drive requests of the sixteen-bit port to its pin driver.
`timescale 1ns/10ps
interface pin_ctrl_if;
  logic [15:0] outData;
  logic [15:0] outEnable;
  logic [15:0] openDrain;
  logic [15:0] pinO;
  logic [15:0] pinOe;

  modport ctrl (output outData, output outEnable, output openDrain, input pinO, input pinOe);
  modport drv  (input outData, input outEnable, input openDrain, output pinO, output pinOe);
endinterface

// ===== src/pin_sync.sv
// Two-flop synchroniser for pin levels entering the core clock domain.
`timescale 1ns/10ps
module pin_sync #(
  parameter int W = 1
) (
  input  wire logic         core_clk,
  input  wire logic         sys_rst,
  input  wire logic [W-1:0] asyncIn,
  output logic      [W-1:0] syncOut
);

  logic [W-1:0] meta_r;

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      meta_r  <= '0;
      syncOut <= '0;
    end
    else
    begin
      meta_r  <= asyncIn;
      syncOut <= meta_r;
    end
  end

endmodule

// ===== src/port9_pin_driver.sv
// Per-bit push-pull or open-drain pin driver for the sixteen-bit port.
`timescale 1ns/10ps
module port9_pin_driver (
  input  wire logic core_clk,
  input  wire logic sys_rst,
  pin_ctrl_if.drv   pins
);

  genvar b;
  generate
    for (b = 0; b < 16; b++)
    begin : g_bit
      logic oNxt;
      logic oeNxt;
      logic o_r;
      logic oe_r;

      // Open drain pulls low for a 0 and releases the pin for a 1.
      assign oNxt  = pins.openDrain[b] ? 1'b0 : pins.outData[b];
      assign oeNxt = pins.outEnable[b] & (~pins.openDrain[b] | ~pins.outData[b]);

      always_ff @(posedge core_clk)
      begin
        if (sys_rst)
        begin
          o_r  <= 1'b0;
          oe_r <= 1'b0;
        end
        else
        begin
          o_r  <= oNxt;
          oe_r <= oeNxt;
        end
      end

      assign pins.pinO[b]  = o_r;
      assign pins.pinOe[b] = oe_r;
    end
  endgenerate

endmodule

// ===== src/port_drive_and_direction_regs.sv
// Drive-type, direction and output-latch registers of three ports behind a Wishbone slave.
//
// How it works
// - Drive-type bit 0 push-pull, 1 open-drain.
// - Drive-type register resets to zero, read/write.
// - Only variant's implemented drive-type bits exist.
// - Drive-type register reachable as one halfword.
// - Drive-type also reachable as low/high bytes.
// - High byte register maps drive bits 8-15.
// - Port C mode resets FF; bit0 selects direction.
// - Port C pin direction chosen by software.
// - Port D pin direction chosen by software.
// - Port D latch bit 5 drives pin level.
// - Output latch as halfword or low byte.
// - Port D mode as halfword or low byte.
// - Flash programming mode takes port D pin over.
//
// Decided for this implementation: the Wishbone interface to the registers.
`timescale 1ns/10ps
module port_drive_and_direction_regs #(
  parameter logic [15:0] DRIVE_IMPL_MASK = port_regs_pkg::DRIVE_IMPL_MAX
) (
  input  wire logic                 core_clk,
  input  wire logic                 sys_rst,
  input  wire logic                 wb_cyc_i,
  input  wire logic                 wb_stb_i,
  input  wire logic                 wb_we_i,
  input  wire port_regs_pkg::adr_t  wb_adr_i,
  input  wire port_regs_pkg::sel_t  wb_sel_i,
  input  wire port_regs_pkg::dat_t  wb_dat_i,
  output port_regs_pkg::dat_t       wb_dat_o,
  output logic                      wb_ack_o,
  input  wire logic [15:0]          port9OutData,
  input  wire logic [15:0]          port9OutEnable,
  output logic      [15:0]          port9PinO,
  output logic      [15:0]          port9PinOe,
  input  wire logic                 portcOutData,
  input  wire logic                 portcPinI,
  output logic                      portcPinO,
  output logic                      portcPinOe,
  input  wire logic                 portdPinI,
  output logic                      portdPinO,
  output logic                      portdPinOe,
  input  wire logic                 flashModeEntry,
  output logic                      flash_mode_input,
  output logic                      portcPinLevel,
  output logic                      portdPinLevel
);

  import port_regs_pkg::*;

  // Bus handshake states.
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK  = 2'b10
  } bus_state_e;

  bus_state_e busState_r;
  bus_state_e busState_nxt;

  // Register state.
  logic [15:0] port9_drive_type_r;
  logic [15:0] portd_output_latch_r;
  logic [15:0] portd_direction_mode_r;
  logic [7:0]  portc_direction_mode_r;
  dat_t        rdData_r;
  logic        portcOutData_r;
  logic        portdPinO_r;
  logic        portdPinOe_r;
  logic        portcPinO_r;
  logic        portcPinOe_r;

  // Synchronised pin levels.
  logic [SYNC_W-1:0] pinAsync;
  logic [SYNC_W-1:0] pinSync;
  logic              flashMode;

  // Address decode.
  logic [31:0] wordIdx;
  logic        busReq;
  logic        selDrive;
  logic        selDriveHigh;
  logic        selLatch;
  logic        selDmode;
  logic        selCmode;
  logic        selLevel;
  logic        wrStrobe;
  logic        rdStrobe;

  // Byte-lane write enables and masked write values.
  logic        wrDriveLow;
  logic        wrDriveHigh;
  logic [7:0]  driveHighSrc;
  logic [15:0] driveWrVal;
  logic [15:0] port9_drive_type_nxt;
  logic        wrLatch;
  logic [15:0] portd_output_latch_nxt;
  logic        wrDmode;
  logic [15:0] portd_direction_mode_nxt;
  logic        wrCmode;
  logic [7:0]  portc_direction_mode_nxt;

  // Read multiplexer.
  logic [15:0] levelWord;
  dat_t        rdData_nxt;

  // Pin control values.
  logic        portcIsOutput;
  logic        portdIsOutput;
  logic        portdPinO_nxt;
  logic        portdPinOe_nxt;

  pin_ctrl_if port9Bus ();

  // Bus handshake.
  assign wordIdx  = wb_adr_i[IDX_LSB +: 32];
  assign busReq   = wb_cyc_i & wb_stb_i;

  always_comb
  begin
    busState_nxt = busState_r;
    case (busState_r)
      BUS_IDLE:
      begin
        if (busReq)
        begin
          busState_nxt = BUS_ACK;
        end
      end
      BUS_ACK:
      begin
        busState_nxt = BUS_IDLE;
      end
      default:
      begin
        busState_nxt = BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      busState_r <= BUS_IDLE;
    end
    else
    begin
      busState_r <= busState_nxt;
    end
  end

  assign wb_ack_o = (busState_r == BUS_ACK) & busReq;

  // Writes take effect on the edge where the master samples ack.
  assign wrStrobe = wb_ack_o & wb_we_i;
  assign rdStrobe = (busState_r == BUS_IDLE) & busReq & ~wb_we_i;

  assign selDrive     = (wordIdx == DRIVE_TYPE_IDX);
  assign selDriveHigh = (wordIdx == DRIVE_HIGH_IDX);
  assign selLatch     = (wordIdx == LATCH_IDX);
  assign selDmode     = (wordIdx == DMODE_IDX);
  assign selCmode     = (wordIdx == CMODE_IDX);
  assign selLevel     = (wordIdx == PIN_LEVEL_IDX);

  // Drive-type register: halfword at one index, low byte on lane 0, high byte on lane 1.
  // The high-byte register places bits 8 to 15 on lane 0 of its own index.
  assign wrDriveLow   = wrStrobe & selDrive & wb_sel_i[0];
  assign wrDriveHigh  = wrStrobe & ((selDrive & wb_sel_i[1]) | (selDriveHigh & wb_sel_i[0]));
  assign driveHighSrc = selDriveHigh ? wb_dat_i[7:0] : wb_dat_i[15:8];

  assign driveWrVal[7:0]  = wrDriveLow  ? wb_dat_i[7:0] : port9_drive_type_r[7:0];
  assign driveWrVal[15:8] = wrDriveHigh ? driveHighSrc  : port9_drive_type_r[15:8];

  // Bits the variant does not implement stay at zero.
  assign port9_drive_type_nxt = driveWrVal & DRIVE_IMPL_MASK;

  // Port D latch: only the documented bit is writable.
  assign wrLatch = wrStrobe & selLatch & wb_sel_i[0];
  always_comb
  begin
    portd_output_latch_nxt = LATCH_RST;
    portd_output_latch_nxt[LATCH_BIT] = wrLatch ? wb_dat_i[LATCH_BIT]
                                                : portd_output_latch_r[LATCH_BIT];
  end

  // Port D mode: only the direction bit is writable, the others read as one.
  assign wrDmode = wrStrobe & selDmode & wb_sel_i[0];
  always_comb
  begin
    portd_direction_mode_nxt = DMODE_RST;
    portd_direction_mode_nxt[DMODE_BIT] = wrDmode ? wb_dat_i[DMODE_BIT]
                                                  : portd_direction_mode_r[DMODE_BIT];
  end

  // Port C mode: bits 7 to 1 are fixed at one.
  assign wrCmode = wrStrobe & selCmode & wb_sel_i[0];
  always_comb
  begin
    portc_direction_mode_nxt = CMODE_RST;
    portc_direction_mode_nxt[CMODE_BIT] = wrCmode ? wb_dat_i[CMODE_BIT]
                                                  : portc_direction_mode_r[CMODE_BIT];
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      port9_drive_type_r     <= DRIVE_RST;
      portd_output_latch_r   <= LATCH_RST;
      portd_direction_mode_r <= DMODE_RST;
      portc_direction_mode_r <= CMODE_RST;
    end
    else
    begin
      port9_drive_type_r     <= port9_drive_type_nxt;
      portd_output_latch_r   <= portd_output_latch_nxt;
      portd_direction_mode_r <= portd_direction_mode_nxt;
      portc_direction_mode_r <= portc_direction_mode_nxt;
    end
  end

  // Read data, captured when the request is first seen and held through ack.
  always_comb
  begin
    levelWord                = '0;
    levelWord[LVL_PORTC_BIT] = portcPinLevel;
    levelWord[LVL_PORTD_BIT] = portdPinLevel;
    levelWord[LVL_FLASH_BIT] = flashMode;
  end

  always_comb
  begin
    rdData_nxt = '0;
    if (selDrive)
    begin
      rdData_nxt[15:0] = port9_drive_type_r;
    end
    else if (selDriveHigh)
    begin
      rdData_nxt[7:0] = port9_drive_type_r[15:8];
    end
    else if (selLatch)
    begin
      rdData_nxt[15:0] = portd_output_latch_r;
    end
    else if (selDmode)
    begin
      rdData_nxt[15:0] = portd_direction_mode_r;
    end
    else if (selCmode)
    begin
      rdData_nxt[7:0] = portc_direction_mode_r;
    end
    else if (selLevel)
    begin
      rdData_nxt[15:0] = levelWord;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      rdData_r <= '0;
    end
    else if (rdStrobe)
    begin
      rdData_r <= rdData_nxt;
    end
  end

  assign wb_dat_o = rdData_r;

  // Pin input synchronisation.
  assign pinAsync = {flashModeEntry, portdPinI, portcPinI};

  pin_sync #(
    .W (SYNC_W)
  ) u_sync (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .asyncIn  (pinAsync),
    .syncOut  (pinSync)
  );

  assign portcPinLevel    = pinSync[0];
  assign portdPinLevel    = pinSync[1];
  assign flashMode        = pinSync[2];
  assign flash_mode_input = portdPinLevel;

  // Sixteen-bit port drive.
  assign port9Bus.outData   = port9OutData;
  assign port9Bus.outEnable = port9OutEnable;
  assign port9Bus.openDrain = port9_drive_type_r;

  port9_pin_driver u_port9 (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .pins     (port9Bus)
  );

  assign port9PinO  = port9Bus.pinO;
  assign port9PinOe = port9Bus.pinOe;

  // Port C: the mode bit alone sets the direction.
  assign portcIsOutput = ~portc_direction_mode_r[CMODE_BIT];

  // Port D: flash programming mode forces the pin to an input with no register help.
  assign portdIsOutput  = ~portd_direction_mode_r[DMODE_BIT] & ~flashMode;
  assign portdPinO_nxt  = portd_output_latch_r[LATCH_BIT];
  assign portdPinOe_nxt = portdIsOutput;

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      portcOutData_r <= 1'b0;
      portcPinO_r    <= 1'b0;
      portcPinOe_r   <= 1'b0;
      portdPinO_r    <= 1'b0;
      portdPinOe_r   <= 1'b0;
    end
    else
    begin
      portcOutData_r <= portcOutData;
      portcPinO_r    <= portcOutData_r;
      portcPinOe_r   <= portcIsOutput;
      portdPinO_r    <= portdPinO_nxt;
      portdPinOe_r   <= portdPinOe_nxt;
    end
  end

  assign portcPinO  = portcPinO_r;
  assign portcPinOe = portcPinOe_r;
  assign portdPinO  = portdPinO_r;
  assign portdPinOe = portdPinOe_r;

endmodule

// ===== test/port_drive_and_direction_regs_checker.sv
// Concurrent checks on the ports of the port control block.
`timescale 1ns/10ps
module port_drive_and_direction_regs_checker (
  input wire logic                core_clk,
  input wire logic                sys_rst,
  input wire logic                wb_cyc_i,
  input wire logic                wb_stb_i,
  input wire logic                wb_we_i,
  input wire port_regs_pkg::dat_t wb_dat_o,
  input wire logic                wb_ack_o,
  input wire logic [15:0]         port9OutData,
  input wire logic [15:0]         port9OutEnable,
  input wire logic [15:0]         port9PinO,
  input wire logic [15:0]         port9PinOe,
  input wire logic                portcOutData,
  input wire logic                portcPinI,
  input wire logic                portcPinO,
  input wire logic                portcPinOe,
  input wire logic                portdPinI,
  input wire logic                portdPinOe,
  input wire logic                flashModeEntry,
  input wire logic                flash_mode_input,
  input wire logic                portcPinLevel,
  input wire logic                portdPinLevel
);
  import port_regs_pkg::*;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_after_req: assert property ($rose(wb_cyc_i && wb_stb_i) |=> wb_ack_o)
    else $error("ack missing after request");
  a_ack_needs_req: assert property (wb_ack_o |-> wb_cyc_i && wb_stb_i)
    else $error("ack without request");
  a_rdata_holds: assert property (!$past(wb_cyc_i && wb_stb_i && !wb_we_i) |-> $stable(wb_dat_o))
    else $error("read data changed without read");
  a_pin_data_only: assert property ((port9PinO & ~$past(port9OutData)) == 16'h0000)
    else $error("port9 pin high without data");
  a_pin_en_only: assert property ((port9PinOe & ~$past(port9OutEnable)) == 16'h0000)
    else $error("port9 pin driven without enable");
  a_flash_input: assert property (flashModeEntry [*4] |-> !portdPinOe)
    else $error("port D driven in flash mode");
  a_levels_sync: assert property (!$past(sys_rst) && !$past(sys_rst, 2) |->
    {portcPinLevel, portdPinLevel, flash_mode_input} == $past({portcPinI, portdPinI, portdPinI}, 2))
    else $error("pin levels not two cycles behind");
  a_portc_out: assert property (!$past(sys_rst) && !$past(sys_rst, 2) && portcPinOe |->
    portcPinO == $past(portcOutData, 2))
    else $error("port C output data mismatch");
endmodule

bind port_drive_and_direction_regs port_drive_and_direction_regs_checker u_chk (
  .core_clk, .sys_rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_dat_o, .wb_ack_o,
  .port9OutData, .port9OutEnable, .port9PinO, .port9PinOe, .portcOutData, .portcPinI,
  .portcPinO, .portcPinOe, .portdPinI, .portdPinOe, .flashModeEntry, .flash_mode_input,
  .portcPinLevel, .portdPinLevel
);

// ===== test/port_drive_and_direction_regs_test.sv
// Self-checking bench for the port drive and direction registers.
`timescale 1ns/10ps
module port_drive_and_direction_regs_test;
  import port_regs_pkg::*;
  logic        core_clk, sys_rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  adr_t        wb_adr_i;
  sel_t        wb_sel_i;
  dat_t        wb_dat_i, wb_dat_o, q;
  logic [15:0] port9OutData, port9OutEnable, port9PinO, port9PinOe, pd, pe, dr;
  logic        portcOutData, portcPinI, portcPinO, portcPinOe, portdPinI, portdPinO, portdPinOe;
  logic        flashModeEntry, flash_mode_input, portcPinLevel, portdPinLevel;
  int          fails, num_checks, tmo;

  port_drive_and_direction_regs u_dut (
    .core_clk, .sys_rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .port9OutData, .port9OutEnable, .port9PinO, .port9PinOe,
    .portcOutData, .portcPinI, .portcPinO, .portcPinOe, .portdPinI, .portdPinO, .portdPinOe,
    .flashModeEntry, .flash_mode_input, .portcPinLevel, .portdPinLevel
  );

  initial
  begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  task automatic wrap_up;
    $display("Comparisons %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  always @(posedge core_clk)
  begin
    tmo++;
    if (tmo == 3000)
    begin
      fails++;
      wrap_up;
    end
  end

  task automatic chk(input string n, input dat_t e, input dat_t s);
    num_checks++;
    if (s !== e)
    begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  // Classic single cycle; entered just after a rising edge, leaves one idle cycle.
  task automatic bus(input logic [31:0] i, input logic we, input sel_t s, input dat_t d);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= {i, 2'b00};
    wb_sel_i <= s;
    wb_dat_i <= d;
    do @(posedge core_clk); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic wr(input logic [31:0] i, input sel_t s, input dat_t d);
    bus(i, 1'b1, s, d);
  endtask

  task automatic rd(input logic [31:0] i, input dat_t e, input string n);
    bus(i, 1'b0, 4'hF, 32'h0);
    chk(n, e, q);
  endtask

  initial
  begin
    {fails, num_checks, tmo} = '0;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
    {port9OutData, port9OutEnable, portcOutData, portcPinI, portdPinI, flashModeEntry} = '0;
    sys_rst = 1'b1;
    tick(12);
    sys_rst <= 1'b0;
    tick(1);
    rd(DRIVE_TYPE_IDX, 32'h0, "drive reset");
    rd(LATCH_IDX, 32'h0, "latch reset");
    rd(CMODE_IDX, 32'hFF, "portc mode reset");
    rd(DMODE_IDX, 32'(DMODE_RST), "portd mode reset");
    rd(32'h00000010, 32'h0, "unmapped read");
    wr(DRIVE_TYPE_IDX, 4'h3, 32'hFFFF);
    rd(DRIVE_TYPE_IDX, 32'(DRIVE_IMPL_MAX), "drive implemented");
    wr(DRIVE_HIGH_IDX, 4'h1, 32'h5A);
    rd(DRIVE_HIGH_IDX, 32'h5A, "drive high byte");
    wr(DRIVE_TYPE_IDX, 4'h1, 32'h0);
    rd(DRIVE_TYPE_IDX, 32'h5A00, "drive bytes");
    dr = 16'h5A00;
    for (int k = 0; k < 2; k++)
    begin
      pd = k ? 16'h0FF0 : 16'hF00F;
      pe = k ? 16'hFFFF : 16'h33CC;
      port9OutData <= pd;
      port9OutEnable <= pe;
      tick(2);
      chk("port9 out", 32'(pd & ~dr), 32'(port9PinO));
      chk("port9 enable", 32'(pe & ~(dr & pd)), 32'(port9PinOe));
    end
    portcOutData <= 1'b1;
    wr(CMODE_IDX, 4'h1, 32'h0);
    rd(CMODE_IDX, 32'hFE, "portc mode fixed");
    tick(2);
    chk("portc enable", 32'h1, 32'(portcPinOe));
    chk("portc out", 32'h1, 32'(portcPinO));
    wr(CMODE_IDX, 4'h1, 32'h1);
    tick(2);
    chk("portc input", 32'h0, 32'(portcPinOe));
    wr(LATCH_IDX, 4'h3, 32'hFFFF);
    rd(LATCH_IDX, 32'h20, "latch bit");
    wr(DMODE_IDX, 4'h1, 32'h0);
    rd(DMODE_IDX, 32'hFFDF, "portd mode");
    tick(2);
    chk("portd enable", 32'h1, 32'(portdPinOe));
    chk("portd high", 32'h1, 32'(portdPinO));
    wr(LATCH_IDX, 4'h1, 32'h0);
    tick(2);
    chk("portd low", 32'h0, 32'(portdPinO));
    flashModeEntry <= 1'b1;
    portcPinI <= 1'b1;
    portdPinI <= 1'b1;
    tick(5);
    chk("flash input", 32'h0, 32'(portdPinOe));
    chk("level outputs", 32'h7, 32'({flash_mode_input, portdPinLevel, portcPinLevel}));
    rd(PIN_LEVEL_IDX, 32'h7, "pin levels");
    flashModeEntry <= 1'b0;
    tick(5);
    chk("portd again", 32'h1, 32'(portdPinOe));
    wrap_up;
  end
endmodule
